/* src/qdac_regs.svh */
// Bit positions, codes, reset values and timing counts of the quad converter link
`ifndef QDAC_REGS_SVH
`define QDAC_REGS_SVH

`define QDAC_WORD_BITS 16
`define QDAC_CODE_BITS 12
`define QDAC_CHANNELS 4
`define QDAC_LOAD_HI 15
`define QDAC_LOAD_LO 14
`define QDAC_PICK_HI 13
`define QDAC_PICK_LO 12
`define QDAC_CODE_HI 11
`define QDAC_ALL_FLAG 11
`define QDAC_PD_CHAN_HI 10
`define QDAC_PD_CHAN_LO 9
`define QDAC_PD_TERM_HI 8
`define QDAC_PD_TERM_LO 7
`define QDAC_LAST_BIT 4'h0f
`define QDAC_CODE_RESET 12'h000
`define QDAC_WORD_RESET 16'h0000
`define QDAC_TERM_RESET 2'h0
// Host side: system and serial clock periods in ns, and serial clock half-period in system cycles
`define QDAC_SYS_PERIOD_NS 20
`define QDAC_SCLK_PERIOD_NS 160
`define QDAC_HALF_CYCLES (`QDAC_SCLK_PERIOD_NS / (2 * `QDAC_SYS_PERIOD_NS))
`define QDAC_HALF_LAST 3'((`QDAC_HALF_CYCLES) - 1)
// Host register word addresses and fields
`define QDAC_ADDR_CMD 2'h0
`define QDAC_ADDR_STATUS 2'h1
`define QDAC_ADDR_COUNT 2'h2
`define QDAC_STAT_BUSY 0
`define QDAC_RD_UNMAPPED 32'h0000_0000

`endif

/* src/qdac_pkg.sv */
// Types for the host and device ends of the quad converter link
package qdac_pkg;
  typedef enum logic [1:0] {
    QDAC_LD_STORE = 2'h0,
    QDAC_LD_UPDATE = 2'h1,
    QDAC_LD_BOTH = 2'h2,
    QDAC_LD_BROADCAST = 2'h3
  } qdac_load_t;

  typedef enum logic [1:0] {
    QDAC_BC_NONE = 2'h0,
    QDAC_BC_UPDATE_ALL = 2'h1,
    QDAC_BC_LOAD_ALL = 2'h2,
    QDAC_BC_POWER_OFF = 2'h3
  } qdac_bcast_t;

  typedef enum logic [1:0] {
    QDAC_TERM_HIZ = 2'h0,
    QDAC_TERM_1K = 2'h1,
    QDAC_TERM_100K = 2'h2,
    QDAC_TERM_HIZ2 = 2'h3
  } qdac_term_t;

  typedef enum logic [1:0] {
    QDAC_RX_WAIT_HIGH = 2'h0,
    QDAC_RX_IDLE = 2'h1,
    QDAC_RX_SHIFT = 2'h2,
    QDAC_RX_DONE = 2'h3
  } qdac_rx_state_t;

  typedef enum logic [2:0] {
    QDAC_TX_IDLE = 3'h0,
    QDAC_TX_SETUP = 3'h1,
    QDAC_TX_SHIFT = 3'h2,
    QDAC_TX_HOLD = 3'h3,
    QDAC_TX_GAP = 3'h4
  } qdac_tx_state_t;
endpackage : qdac_pkg

/* src/qdac_link_if.sv */
// Three-wire serial link between host controller and converter
interface qdac_link_if;
  logic frameSyncN;
  logic serialClk;
  logic serialData;

  modport device (input frameSyncN, input serialClk, input serialData);
  modport host (output frameSyncN, output serialClk, output serialData);
endinterface : qdac_link_if

/* src/qdac_sync2.sv */
// Two-flop synchroniser for a group of asynchronous levels
module qdac_sync2 #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic clkEn,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      meta_q <= INIT;
      syncOut <= INIT;
    end else if (clkEn) begin
      meta_q <= asyncIn;
      syncOut <= meta_q;
    end
  end
endmodule : qdac_sync2

/* src/qdac_device.sv */
// Converter end: serial command receiver and per-channel code and power-down registers
`include "qdac_regs.svh"

module qdac_device (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic clkEn,
  qdac_link_if.device link,
  output logic [`QDAC_CHANNELS-1:0][`QDAC_CODE_BITS-1:0] chanCode,
  output logic [`QDAC_CHANNELS-1:0] chanPowerOff,
  output logic [`QDAC_CHANNELS-1:0][1:0] chanTerm,
  output logic frameDone,
  output logic frameAbort
);
  // ==========================================================
  // Pin synchronisers
  // ==========================================================
  logic frameSyncNS;
  logic serialClkS;
  logic serialDataS;
  logic serialClkPrev_q;

  qdac_sync2 #(
    .WIDTH(3),
    .INIT(3'h6)
  ) u_pinSync (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .clkEn(clkEn),
    .asyncIn({link.frameSyncN, link.serialClk, link.serialData}),
    .syncOut({frameSyncNS, serialClkS, serialDataS})
  );

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      serialClkPrev_q <= 1'b1;
    end else if (clkEn) begin
      serialClkPrev_q <= serialClkS;
    end
  end

  wire sclkFall = serialClkPrev_q & ~serialClkS;

  // ==========================================================
  // Frame receiver
  // ==========================================================
  qdac_pkg::qdac_rx_state_t rxState_q;
  qdac_pkg::qdac_rx_state_t rxState_d;
  logic [`QDAC_WORD_BITS-1:0] shift_q;
  logic [3:0] bitCnt_q;

  wire inShift = (rxState_q == qdac_pkg::QDAC_RX_SHIFT);
  wire takeBit = inShift & ~frameSyncNS & sclkFall;
  wire lastBit = takeBit & (bitCnt_q == `QDAC_LAST_BIT);
  wire abortNow = inShift & frameSyncNS;
  // Word as it stands once the sixteenth bit is in, first bit at the top
  wire [`QDAC_WORD_BITS-1:0] fullWord = {shift_q[`QDAC_WORD_BITS-2:0], serialDataS};

  always_comb begin
    rxState_d = rxState_q;
    case (rxState_q)
      qdac_pkg::QDAC_RX_WAIT_HIGH: begin
        if (frameSyncNS) begin
          rxState_d = qdac_pkg::QDAC_RX_IDLE;
        end
      end
      qdac_pkg::QDAC_RX_IDLE: begin
        if (!frameSyncNS) begin
          rxState_d = qdac_pkg::QDAC_RX_SHIFT;
        end
      end
      qdac_pkg::QDAC_RX_SHIFT: begin
        if (abortNow) begin
          rxState_d = qdac_pkg::QDAC_RX_IDLE;
        end else if (lastBit) begin
          rxState_d = qdac_pkg::QDAC_RX_DONE;
        end
      end
      qdac_pkg::QDAC_RX_DONE: begin
        if (frameSyncNS) begin
          rxState_d = qdac_pkg::QDAC_RX_IDLE;
        end
      end
      default: begin
        rxState_d = qdac_pkg::QDAC_RX_WAIT_HIGH;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rxState_q <= qdac_pkg::QDAC_RX_WAIT_HIGH;
    end else if (clkEn) begin
      rxState_q <= rxState_d;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      shift_q <= `QDAC_WORD_RESET;
      bitCnt_q <= 4'h0;
    end else if (clkEn) begin
      if (rxState_q == qdac_pkg::QDAC_RX_IDLE) begin
        bitCnt_q <= 4'h0;
      end else if (takeBit) begin
        shift_q <= fullWord;
        bitCnt_q <= bitCnt_q + 4'h1;
      end
    end
  end

  // ==========================================================
  // Frame status pulses
  // ==========================================================
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      frameDone <= 1'b0;
      frameAbort <= 1'b0;
    end else if (clkEn) begin
      frameDone <= lastBit;
      frameAbort <= abortNow;
    end
  end

  // ==========================================================
  // Command decode
  // ==========================================================
  wire [1:0] loadCtrl = fullWord[`QDAC_LOAD_HI:`QDAC_LOAD_LO];
  wire [1:0] chanPick = fullWord[`QDAC_PICK_HI:`QDAC_PICK_LO];
  wire [`QDAC_CODE_BITS-1:0] newCode = fullWord[`QDAC_CODE_HI:0];
  wire broadcast = (loadCtrl == qdac_pkg::QDAC_LD_BROADCAST);
  wire powerOffCmd = broadcast & (chanPick == qdac_pkg::QDAC_BC_POWER_OFF);
  wire allChannelsFlag = fullWord[`QDAC_ALL_FLAG];
  wire [1:0] pdChan = fullWord[`QDAC_PD_CHAN_HI:`QDAC_PD_CHAN_LO];
  wire [1:0] pdTerm = fullWord[`QDAC_PD_TERM_HI:`QDAC_PD_TERM_LO];

  // True when a completed word of the given load action reaches channel ch
  function automatic logic hitsChan(input logic [1:0] ch, input logic [1:0] ld, input logic [1:0] bc,
    input logic [1:0] ldIn, input logic [1:0] pickIn);
    hitsChan = (ldIn != qdac_pkg::QDAC_LD_BROADCAST && ldIn == ld && pickIn == ch)
      || (ldIn == qdac_pkg::QDAC_LD_BROADCAST && pickIn == bc);
  endfunction : hitsChan

  // True when a power-down word names channel ch, alone or through the all-channels flag
  function automatic logic pdHitsChan(input logic [1:0] ch, input logic allFlag, input logic [1:0] pdPick);
    pdHitsChan = allFlag | (pdPick == ch);
  endfunction : pdHitsChan

  // ==========================================================
  // Per-channel input and output code registers
  // ==========================================================
  logic [`QDAC_CHANNELS-1:0][`QDAC_CODE_BITS-1:0] inReg_q;

  for (genvar ch = 0; ch < `QDAC_CHANNELS; ch++) begin : g_chan
    wire [1:0] chId = 2'(ch);
    // Store and update cases; load 10 covers both registers
    wire storeOnly = hitsChan(chId, qdac_pkg::QDAC_LD_STORE, qdac_pkg::QDAC_BC_LOAD_ALL, loadCtrl, chanPick);
    wire loadBoth = hitsChan(chId, qdac_pkg::QDAC_LD_BOTH, qdac_pkg::QDAC_BC_LOAD_ALL, loadCtrl, chanPick);
    wire updateOut = hitsChan(chId, qdac_pkg::QDAC_LD_UPDATE, qdac_pkg::QDAC_BC_UPDATE_ALL, loadCtrl, chanPick);
    wire storeIn = lastBit & (storeOnly | loadBoth);
    wire loadOutNew = lastBit & loadBoth;
    wire loadOutOld = lastBit & updateOut;
    wire powerHit = lastBit & powerOffCmd & pdHitsChan(chId, allChannelsFlag, pdChan);

    always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
        inReg_q[ch] <= `QDAC_CODE_RESET;
        chanCode[ch] <= `QDAC_CODE_RESET;
        chanPowerOff[ch] <= 1'b0;
        chanTerm[ch] <= `QDAC_TERM_RESET;
      end else if (clkEn) begin
        if (storeIn) begin
          inReg_q[ch] <= newCode;
        end
        // Writing the output register brings the channel back up
        if (loadOutNew) begin
          chanCode[ch] <= newCode;
          chanPowerOff[ch] <= 1'b0;
        end else if (loadOutOld) begin
          chanCode[ch] <= inReg_q[ch];
          chanPowerOff[ch] <= 1'b0;
        end else if (powerHit) begin
          chanPowerOff[ch] <= 1'b1;
          chanTerm[ch] <= pdTerm;
        end
      end
    end
  end
endmodule : qdac_device

/* src/qdac_host.sv */
// Host end: Avalon-MM command registers and serial word transmitter with clock divider
`include "qdac_regs.svh"

module qdac_host (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic clkEn,
  input wire logic [1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  qdac_link_if.host link
);
  // ==========================================================
  // Register bus
  // ==========================================================
  qdac_pkg::qdac_tx_state_t txState_q;
  logic [`QDAC_WORD_BITS-1:0] lastWord_q;
  logic [`QDAC_WORD_BITS-1:0] txShift_q;
  logic [15:0] frameCount_q;
  logic syncN_q;
  logic sclk_q;
  logic [3:0] bitCnt_q;
  logic [2:0] divCnt_q;

  wire busy = (txState_q != qdac_pkg::QDAC_TX_IDLE);
  wire cmdAddr = (avs_address == `QDAC_ADDR_CMD);
  // A command write waits while a frame is on the link
  wire canAccept = !(avs_write && cmdAddr && busy);
  wire request = avs_read | avs_write;
  wire grant = request & avs_waitrequest & canAccept;
  wire complete = request & ~avs_waitrequest;
  wire startFrame = complete & avs_write & cmdAddr;
  wire [31:0] readMux = (avs_address == `QDAC_ADDR_CMD) ? {16'h0000, lastWord_q} :
                        (avs_address == `QDAC_ADDR_STATUS) ? {31'h0000_0000, busy} :
                        (avs_address == `QDAC_ADDR_COUNT) ? {16'h0000, frameCount_q} : `QDAC_RD_UNMAPPED;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
    end else if (clkEn) begin
      avs_waitrequest <= ~grant;
      if (grant) begin
        avs_readdata <= readMux;
      end
    end
  end

  // ==========================================================
  // Serial transmitter
  // ==========================================================
  wire tick = (divCnt_q == `QDAC_HALF_LAST);

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      txState_q <= qdac_pkg::QDAC_TX_IDLE;
      lastWord_q <= `QDAC_WORD_RESET;
      txShift_q <= `QDAC_WORD_RESET;
      frameCount_q <= 16'h0000;
      syncN_q <= 1'b1;
      sclk_q <= 1'b1;
      bitCnt_q <= 4'h0;
      divCnt_q <= 3'h0;
    end else if (clkEn) begin
      divCnt_q <= (tick || !busy) ? 3'h0 : divCnt_q + 3'h1;
      case (txState_q)
        qdac_pkg::QDAC_TX_IDLE: begin
          if (startFrame) begin
            lastWord_q <= avs_writedata[`QDAC_WORD_BITS-1:0];
            txShift_q <= avs_writedata[`QDAC_WORD_BITS-1:0];
            syncN_q <= 1'b0;
            bitCnt_q <= 4'h0;
            txState_q <= qdac_pkg::QDAC_TX_SETUP;
          end
        end
        qdac_pkg::QDAC_TX_SETUP: begin
          if (tick) begin
            sclk_q <= 1'b0;
            txState_q <= qdac_pkg::QDAC_TX_SHIFT;
          end
        end
        qdac_pkg::QDAC_TX_SHIFT: begin
          if (tick && !sclk_q) begin
            sclk_q <= 1'b1;
            if (bitCnt_q == `QDAC_LAST_BIT) begin
              txState_q <= qdac_pkg::QDAC_TX_HOLD;
            end else begin
              txShift_q <= {txShift_q[`QDAC_WORD_BITS-2:0], 1'b0};
              bitCnt_q <= bitCnt_q + 4'h1;
            end
          end else if (tick) begin
            sclk_q <= 1'b0;
          end
        end
        qdac_pkg::QDAC_TX_HOLD: begin
          if (tick) begin
            syncN_q <= 1'b1;
            frameCount_q <= frameCount_q + 16'h0001;
            txState_q <= qdac_pkg::QDAC_TX_GAP;
          end
        end
        qdac_pkg::QDAC_TX_GAP: begin
          if (tick) begin
            txState_q <= qdac_pkg::QDAC_TX_IDLE;
          end
        end
        default: begin
          txState_q <= qdac_pkg::QDAC_TX_IDLE;
        end
      endcase
    end
  end

  assign link.frameSyncN = syncN_q;
  assign link.serialClk = sclk_q;
  assign link.serialData = txShift_q[`QDAC_WORD_BITS-1];
endmodule : qdac_host

/* tb/qdac_link_checker.sv */
// Concurrent checks on the serial link joining host and device ends
module qdac_link_checker (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic frameSyncN,
  input wire logic serialClk,
  input wire logic serialData,
  input wire logic frameDone,
  input wire logic frameAbort
);
  // ==========================================
  // Falling edges counted within a frame
  logic [4:0] fallCnt_q;
  logic [4:0] fallCnt_d;
  logic clkPrev_q;
  logic clkFell;
  assign clkFell = clkPrev_q & ~serialClk;
  assign fallCnt_d = frameSyncN ? 5'h00 : (clkFell ? fallCnt_q + 5'h01 : fallCnt_q);
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      fallCnt_q <= 5'h00;
      clkPrev_q <= 1'b1;
    end else begin
      fallCnt_q <= fallCnt_d;
      clkPrev_q <= serialClk;
    end
  end
  // ==========================================
  // Properties
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  a_clk_idle_high: assert property (frameSyncN |-> serialClk)
    else $error("serial clock low outside a frame");
  a_sync_lead: assert property ($fell(frameSyncN) |-> serialClk [*4] ##1 !serialClk)
    else $error("sync to first fall spacing wrong");
  a_half_period: assert property ($fell(serialClk) |-> !serialClk [*4] ##1 serialClk)
    else $error("serial clock low phase wrong");
  a_data_steady: assert property ((!frameSyncN && !$fell(frameSyncN) && $changed(serialData)) |-> $rose(serialClk))
    else $error("data moved off the rising clock");
  a_sixteen_falls: assert property ($rose(frameSyncN) |-> fallCnt_q == 5'h10)
    else $error("sync released without sixteen falls");
  a_fall_limit: assert property (fallCnt_q <= 5'h10)
    else $error("more than sixteen falls in a frame");
  a_done_timing: assert property ((clkFell && fallCnt_q == 5'h0f) |-> ##[2:5] frameDone)
    else $error("word not taken after sixteenth fall");
  a_done_full: assert property (frameDone |-> fallCnt_q == 5'h10 && !frameSyncN)
    else $error("word taken before sixteen bits");
  a_done_pulse: assert property (frameDone |=> !frameDone)
    else $error("done pulse longer than one cycle");
  a_no_abort: assert property ($rose(frameSyncN) |-> !frameAbort [*6])
    else $error("full frame reported as aborted");
  c_frame: cover property (frameDone);
  c_release: cover property ($rose(frameSyncN));
  c_first_fall: cover property (clkFell && fallCnt_q == 5'h00);
endmodule : qdac_link_checker

/* tb/testbench.sv */
// Self-checking bench: host and device joined, plus a hand-driven second link
`include "qdac_regs.svh"
`define CHK(nm, exp, got) begin n_tests++; if ((got) !== (exp)) begin n_mismatch++; $display("mismatch %s expected %0h seen %0h", nm, exp, got); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic clkEn = 1'b1;
  logic [1:0] avs_address = 2'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [3:0][11:0] chanCode;
  logic [3:0][11:0] chanCode2;
  logic [3:0] chanPowerOff;
  logic [3:0][1:0] chanTerm;
  logic frameDone;
  logic frameAbort;
  logic done2;
  logic abort2;
  logic syncB = 1'b1;
  logic clkB = 1'b1;
  logic dataB = 1'b0;
  logic [3:0][11:0] expCode = '0;
  logic [3:0][11:0] expIn = '0;
  logic [3:0] expPd = '0;
  logic [3:0][1:0] expTerm = '0;
  int n_mismatch = 0;
  int n_tests = 0;
  int seed = 15;
  int frames = 0;
  int nDone1 = 0;
  int nDone2 = 0;
  int nAbort2 = 0;
  logic [15:0] corner [15] = '{16'h0123, 16'h1fff, 16'h4000, 16'hafff, 16'hb000, 16'h5000, 16'hc555, 16'hd000,
    16'he800, 16'hf880, 16'hf300, 16'hf780, 16'h2abc, 16'h7000, 16'hf000};
  qdac_link_if link();
  qdac_link_if link2();
  assign link2.frameSyncN = syncB;
  assign link2.serialClk = clkB;
  assign link2.serialData = dataB;
  qdac_host qdac_host_i (.clk_sys, .sys_rst, .clkEn, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .link(link.host));
  qdac_device qdac_device_i (.clk_sys, .sys_rst, .clkEn, .link(link.device), .chanCode, .chanPowerOff,
    .chanTerm, .frameDone, .frameAbort);
  qdac_device qdac_device_i2 (.clk_sys, .sys_rst, .clkEn, .link(link2.device), .chanCode(chanCode2),
    .chanPowerOff(), .chanTerm(), .frameDone(done2), .frameAbort(abort2));
  qdac_link_checker qdac_link_checker_i (.clk_sys, .sys_rst, .frameSyncN(link.frameSyncN),
    .serialClk(link.serialClk), .serialData(link.serialData), .frameDone, .frameAbort);
  always #10 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    nDone1 <= nDone1 + int'(frameDone === 1'b1);
    nDone2 <= nDone2 + int'(done2 === 1'b1);
    nAbort2 <= nAbort2 + int'(abort2 === 1'b1);
  end
  // ==========================================
  // Expected channel state
  function automatic void apply(input logic [15:0] w);
    logic [1:0] ld;
    logic [1:0] pk;
    ld = w[15:14];
    pk = w[13:12];
    if (ld != 2'h3) begin
      if (ld != 2'h1) expIn[pk] = w[11:0];
      if (ld != 2'h0) expCode[pk] = expIn[pk];
      if (ld != 2'h0) expPd[pk] = 1'b0;
    end else if (pk == 2'h3) begin
      for (int c = 0; c < 4; c++) begin
        if (w[11] || w[10:9] == c[1:0]) begin
          expPd[c] = 1'b1;
          expTerm[c] = w[8:7];
        end
      end
    end else if (pk != 2'h0) begin
      for (int c = 0; c < 4; c++) begin
        if (pk == 2'h2) expIn[c] = w[11:0];
        expCode[c] = expIn[c];
        expPd[c] = 1'b0;
      end
    end
  endfunction : apply
  // ==========================================
  // Bus, link and report tasks
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : wrap_up
  task automatic bus(input logic wr, input logic [1:0] addr, input logic [31:0] wd, output logic [31:0] rd);
    int k;
    k = 0;
    @(posedge clk_sys);
    avs_address <= addr;
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= wd;
    do begin
      @(posedge clk_sys);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 400);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (k >= 400) begin
      n_mismatch++;
      wrap_up();
    end
  endtask : bus
  task automatic send(input logic [15:0] w);
    logic [31:0] rd;
    int k;
    bus(1'b1, `QDAC_ADDR_CMD, {16'($random(seed)), w}, rd);
    apply(w);
    frames++;
    k = 0;
    do begin
      bus(1'b0, `QDAC_ADDR_STATUS, 32'h0000_0000, rd);
      k++;
    end while (rd[`QDAC_STAT_BUSY] !== 1'b0 && k < 100);
    if (k >= 100) begin
      n_mismatch++;
      wrap_up();
    end
    `CHK("code", expCode, chanCode)
    `CHK("powered_off", expPd, chanPowerOff)
    `CHK("termination", expTerm, chanTerm)
    bus(1'b0, `QDAC_ADDR_CMD, 32'h0000_0000, rd);
    `CHK("cmd", w, rd[15:0])
  endtask : send
  task automatic drive2(input logic [31:0] w, input int n);
    syncB <= 1'b0;
    for (int i = 0; i < n; i++) begin
      dataB <= w[31-i];
      repeat (4) @(posedge clk_sys);
      clkB <= 1'b0;
      repeat (4) @(posedge clk_sys);
      clkB <= 1'b1;
    end
    repeat (4) @(posedge clk_sys);
    syncB <= 1'b1;
    dataB <= ~dataB;
    repeat (12) @(posedge clk_sys);
  endtask : drive2
  // ==========================================
  // Main sequence
  initial begin
    logic [31:0] rd;
    repeat (10) @(posedge clk_sys);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk_sys);
    `CHK("reset_code", expCode, chanCode)
    `CHK("reset_pd", expPd, chanPowerOff)
    bus(1'b1, 2'h3, 32'hffff_ffff, rd);
    bus(1'b0, 2'h3, 32'h0000_0000, rd);
    `CHK("unmapped", 32'h0000_0000, rd)
    foreach (corner[i]) send(corner[i]);
    repeat (30) send(16'($random(seed)));
    bus(1'b0, `QDAC_ADDR_COUNT, 32'h0000_0000, rd);
    `CHK("count", 16'(frames), rd[15:0])
    `CHK("done_pulses", frames, nDone1)
    drive2(32'h8abc_0000, 10);
    `CHK("abort_code", 12'h000, chanCode2[0])
    `CHK("abort_seen", 1, nAbort2)
    drive2(32'h8abc_9555, 20);
    `CHK("extra_edges", 12'habc, chanCode2[0])
    repeat (3) begin
      clkB <= 1'b0;
      repeat (4) @(posedge clk_sys);
      clkB <= 1'b1;
      repeat (4) @(posedge clk_sys);
    end
    drive2(32'h9123_0000, 16);
    `CHK("sync_high_edges", 12'h123, chanCode2[1])
    `CHK("frames_taken", 2, nDone2)
    clkEn <= 1'b0;
    drive2(32'ha555_0000, 16);
    clkEn <= 1'b1;
    `CHK("frozen_code", 12'h000, chanCode2[2])
    `CHK("frozen_done", 2, nDone2)
    drive2(32'ha555_0000, 16);
    `CHK("revived_code", 12'h555, chanCode2[2])
    `CHK("revived_done", 3, nDone2)
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk_sys);
    expCode = '0;
    expIn = '0;
    expPd = '0;
    expTerm = '0;
    `CHK("rerst_code", expCode, chanCode)
    `CHK("rerst_pd", expPd, chanPowerOff)
    `CHK("rerst_code2", expCode, chanCode2)
    bus(1'b0, `QDAC_ADDR_COUNT, 32'h0000_0000, rd);
    `CHK("rerst_count", 32'h0000_0000, rd)
    send(16'h8abc);
    wrap_up();
  end
endmodule : testbench
